// File: logic/drf_pkg.sv
// package: shared constants of the refresh command link
package drf_pkg;
    // ------------------------------------------------------------
    // timing
    // ------------------------------------------------------------
    localparam int CLK_PERIOD_PS   = 10000;
    localparam int BASE_INTERVAL_NS = 7800;  // avg_refresh_interval base, 7.8 us
    localparam int BASE_INTERVAL_CYC = (BASE_INTERVAL_NS * 1000) / CLK_PERIOD_PS;
    localparam int REFRESH_CYCLE_TIME_NS = 350; // refresh_cycle_time default
    localparam int REFRESH_CYCLE_TIME_CYC =
        (REFRESH_CYCLE_TIME_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int PRECHARGE_TIME_NS = 14;   // precharge_time default
    localparam int PRECHARGE_TIME_CYC =
        (PRECHARGE_TIME_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    // ------------------------------------------------------------
    // mode register fields
    // ------------------------------------------------------------
    localparam int MR4_TCR_EN_BIT  = 3;
    localparam int MR4_TCR_RNG_BIT = 2;
    localparam int MR3_RATE_LSB    = 6;
    localparam int MR3_RATE_W      = 3;
    localparam logic [2:0] RATE_FIX1X = 3'h0;
    localparam logic [2:0] RATE_FIX2X = 3'h1;
    localparam logic [2:0] RATE_FIX4X = 3'h2;
    localparam logic [2:0] RATE_OTF12 = 3'h5;
    localparam logic [2:0] RATE_OTF14 = 3'h6;
    // ------------------------------------------------------------
    // postpone / pull-in budget and skip gear
    // ------------------------------------------------------------
    localparam int POSTPONE_1X = 8;
    localparam int BAL_W       = 7;
    localparam int GEAR_COLD   = 4;    // skip all but one of four below 45 C in extended range
    localparam int GEAR_EXT    = 2;    // extended range from 45 to below 85 C: keep one of two
    localparam int COOL_TEMP_C = 45;
    localparam int HOT_TEMP_C  = 85;
    localparam logic [7:0] COOL_TEMP = 8'h2D;
    localparam logic [7:0] HOT_TEMP  = 8'h55;
    localparam logic [2:0] SKIP_NONE = 3'h0;
endpackage

// File: logic/drf_cmd_if.sv
// interface: command bus between controller and device
`timescale 1ns/1ps
interface drf_cmd_if;
    logic csN;      // chip select, low active
    logic actN;     // activate strobe, high for refresh
    logic rasN;     // row strobe on A16
    logic casN;     // column strobe on A15
    logic weN;      // write enable on A14
    logic bg0;      // on-the-fly rate select
    logic [17:0] addr;  // address, ignored for refresh
    logic banksIdle;    // device reports all banks precharged
    modport ctrl (output csN, actN, rasN, casN, weN, bg0, addr, input banksIdle);
    modport dev  (input csN, actN, rasN, casN, weN, bg0, addr, output banksIdle);
endinterface

// File: logic/drf_device.sv
// module: device-side refresh decode, lockout and temperature-controlled skipping
// ------------------------------------------------------------
// Summary of operation
// - low cs/ras/cas, high act/we starts refresh
// - controller refreshes only after precharge idle
// - row comes from internal counter, address ignored
// - banks precharged idle after refresh ends
// - controller sends deselect during refresh cycle time
// - controller issues each refresh separately, average interval
// - deferral at most 8, 16, 32
// - gap at most 9, 17, 33 intervals; busyReq after a full pull-in lets the controller stretch it to 16, 32, 64
// - pull-in up to 8, 16, 32 credited
// - excess pull-ins earn no credit
// - extra refreshes limited per window
// - tcr off: refresh 3.9 or 7.8 us
// - mode four bit 3 enables tcr
// - mode four bit 2 selects extended range
// - tcr registers refreshes, skips by gear
// - normal range skips only below 45 C
// - extended range skips to normal interval
// - controller refreshes every 3.9 us extended
// - controller programs matching temperature range
// - mode three bits 8:6 select rate
// - interval halves in 2x, quarters 4x
// ------------------------------------------------------------
`timescale 1ns/1ps
module drf_device #(
    parameter int ROW_W = 16,
    parameter int RFC_CYC = drf_pkg::REFRESH_CYCLE_TIME_CYC
) (
    input  wire logic             clock,        // 100 MHz command clock
    input  wire logic             rst_b,        // async reset, low active
    input  wire logic             clkEn,        // freezes all state when low
    drf_cmd_if.dev                cmd,          // command bus
    input  wire logic [12:0]      modeRegFour,  // mode_reg_four contents
    input  wire logic [12:0]      modeRegThree, // mode_reg_three contents
    input  wire logic [7:0]       caseTemp,     // case temperature, degrees C
    output logic                  refBusy,      // internal refresh in progress
    output logic                  refDone,      // pulse: refresh cycle completed
    output logic                  refSkipped,   // pulse: refresh registered, skipped
    output logic [ROW_W-1:0]      refreshRow,   // internal row counter
    output logic                  rate2x,       // current refresh in 2x or 4x
    output logic                  rate4x        // current refresh in 4x
);
    initial
    begin
        if (ROW_W < 1 || RFC_CYC < 1)
            $error("drf_device: bad parameter");
    end

    logic [2:0]  gearCnt;

    // ------------------------------------------------------------
    // command decode
    // ------------------------------------------------------------
    wire        isRefresh = !cmd.csN && cmd.actN && !cmd.rasN && !cmd.casN && cmd.weN;
    wire [2:0]  rateMode  = modeRegThree[drf_pkg::MR3_RATE_LSB +: drf_pkg::MR3_RATE_W];
    wire        otf       = rateMode == drf_pkg::RATE_OTF12 || rateMode == drf_pkg::RATE_OTF14;
    wire        next2x    = rateMode == drf_pkg::RATE_FIX2X || rateMode == drf_pkg::RATE_FIX4X
                            || (otf && cmd.bg0);
    wire        next4x    = rateMode == drf_pkg::RATE_FIX4X
                            || (rateMode == drf_pkg::RATE_OTF14 && cmd.bg0);
    wire        tcrOn     = modeRegFour[drf_pkg::MR4_TCR_EN_BIT];
    wire        extRange  = modeRegFour[drf_pkg::MR4_TCR_RNG_BIT];
    wire        cold      = caseTemp < drf_pkg::COOL_TEMP;
    wire        warm      = caseTemp < drf_pkg::HOT_TEMP;
    // gear ratio: how many registered refreshes make one executed refresh
    wire [2:0]  gear      = !tcrOn ? 3'h1 :
                            cold ? (extRange ? 3'h4 : 3'h2) :
                            (extRange && warm) ? 3'h2 : 3'h1;
    wire        doRefresh = gearCnt + 3'h1 >= gear;
    wire        accept    = isRefresh && !refBusy;

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    logic [15:0] lockCnt;
    wire  [15:0] rfcCyc = 16'(RFC_CYC);

    always_ff @(posedge clock or negedge rst_b)
    begin
        if (!rst_b)
        begin
            gearCnt    <= drf_pkg::SKIP_NONE;
            lockCnt    <= 16'h0000;
            refBusy    <= 1'b0;
            refDone    <= 1'b0;
            refSkipped <= 1'b0;
            refreshRow <= '0;
            rate2x     <= 1'b0;
            rate4x     <= 1'b0;
            cmd.banksIdle <= 1'b1;
        end
        else if (clkEn)
        begin
            refDone    <= 1'b0;
            refSkipped <= 1'b0;
            if (accept)
            begin
                // address pins are not read; the row comes from refreshRow
                gearCnt <= doRefresh ? 3'h0 : gearCnt + 3'h1;
                rate2x  <= next2x;
                rate4x  <= next4x;
                if (doRefresh)
                begin
                    refBusy       <= 1'b1;
                    cmd.banksIdle <= 1'b0;
                    lockCnt       <= rfcCyc;
                end
                else
                    refSkipped <= 1'b1;
            end
            else if (refBusy)
            begin
                if (lockCnt == 16'h0001)
                begin
                    refBusy       <= 1'b0;
                    refDone       <= 1'b1;
                    cmd.banksIdle <= 1'b1;
                    refreshRow    <= refreshRow + 1'b1;
                end
                lockCnt <= lockCnt - 16'h0001;
            end
        end
    end
endmodule

// File: logic/drf_controller.sv
// module: controller-side refresh scheduler with postpone and pull-in balance
`timescale 1ns/1ps
module drf_controller #(
    parameter int INTERVAL_CYC = drf_pkg::BASE_INTERVAL_CYC,
    parameter int RFC_CYC      = drf_pkg::REFRESH_CYCLE_TIME_CYC
) (
    input  wire logic        clock,     // 100 MHz command clock
    input  wire logic        rst_b,     // async reset, low active
    input  wire logic        clkEn,     // freezes all state when low
    drf_cmd_if.ctrl          cmd,       // command bus
    input  wire logic [1:0]  rateSel,   // 0:1x 1:2x 2:4x
    input  wire logic        hotCase,   // case at or above 85 C: halve interval
    input  wire logic        busyReq,   // traffic wants refreshes postponed
    input  wire logic        idleHint,  // bus idle: pull refreshes in
    output logic             refIssued, // pulse: refresh sent
    output logic [6:0]       balance    // signed owed refreshes
);
    initial
    begin
        if (INTERVAL_CYC < 8 || RFC_CYC < 1)
            $error("drf_controller: bad parameter");
    end
    // ------------------------------------------------------------
    // interval and limits
    // ------------------------------------------------------------
    wire [1:0]  shift  = (rateSel > 2'h2 ? 2'h2 : rateSel) + {1'b0, hotCase};
    wire [23:0] ivl    = 24'(INTERVAL_CYC) >> shift;
    wire signed [6:0] lim = 7'(drf_pkg::POSTPONE_1X) <<< (rateSel > 2'h2 ? 2'h2 : rateSel);
    wire signed [6:0] bal = balance;
    logic [23:0] tick;
    logic [15:0] hold;
    wire  tickDue = tick + 24'h1 >= ivl;
    wire  mustRef = bal >= lim;
    wire  canRef  = hold == 16'h0000 && cmd.banksIdle;
    // refresh at a zero balance while busyReq is low, so a drained pull-in credit then never stretches the gap past 9
    wire  wantRef = canRef && (mustRef || (bal >= 0 && !busyReq)
                               || (idleHint && bal > -lim));

    always_ff @(posedge clock or negedge rst_b)
    begin
        if (!rst_b)
        begin
            tick <= 24'h0; hold <= 16'h0; balance <= 7'h00; refIssued <= 1'b0;
            cmd.csN <= 1'b1; cmd.actN <= 1'b1; cmd.rasN <= 1'b1;
            cmd.casN <= 1'b1; cmd.weN <= 1'b1; cmd.bg0 <= 1'b0; cmd.addr <= 18'h00000;
        end
        else if (clkEn)
        begin
            tick <= tickDue ? 24'h0 : tick + 24'h1;
            refIssued <= wantRef;
            {cmd.csN, cmd.rasN, cmd.casN} <= wantRef ? 3'h0 : 3'h7;
            cmd.actN <= 1'b1;
            cmd.weN  <= 1'b1;
            cmd.bg0  <= rateSel != 2'h0;
            hold <= wantRef ? 16'(RFC_CYC) : (hold != 16'h0 ? hold - 16'h1 : 16'h0);
            if (tickDue && !wantRef && bal < lim)
                balance <= 7'(bal + 7'sd1);
            else if (wantRef && !tickDue && bal > -lim)
                balance <= 7'(bal - 7'sd1);
        end
    end
endmodule

// File: bench/drf_link_checker.sv
// checker: refresh timing seen on the controller-device link
`timescale 1ns/1ps
module drf_link_checker #(
    parameter int RFC_CYC      = 35,
    parameter int INTERVAL_CYC = 64
) (
    input wire logic clock,     // command clock
    input wire logic rst_b,     // async reset, low active
    input wire logic csN,       // chip select
    input wire logic actN,      // activate strobe
    input wire logic rasN,      // row strobe
    input wire logic casN,      // column strobe
    input wire logic weN,       // write enable
    input wire logic banksIdle  // all banks idle
);
    logic        isRef;
    logic [7:0]  busyCnt;
    logic [15:0] gapCnt;
    assign isRef = !csN && actN && !rasN && !casN && weN;
    // counters keep the long spans out of the properties
    always_ff @(posedge clock or negedge rst_b)
    begin
        if (!rst_b)
        begin
            busyCnt <= 8'h00;
            gapCnt  <= 16'h0000;
        end
        else
        begin
            busyCnt <= banksIdle ? 8'h00 : busyCnt + 8'h01;
            gapCnt  <= isRef ? 16'h0000 : gapCnt + 16'h0001;
        end
    end
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_b);
    AST_REF_DECODE: assert property (isRef && banksIdle |=> !banksIdle)
        else $error("refresh not taken");
    AST_IDLE_CAUSE: assert property ($fell(banksIdle) |-> $past(isRef))
        else $error("busy without refresh");
    AST_PRECHARGED: assert property (isRef |-> banksIdle)
        else $error("refresh while banks busy");
    AST_DESELECT: assert property (!banksIdle |-> csN)
        else $error("command during refresh cycle");
    AST_RFC_LEN: assert property ($rose(banksIdle) |-> busyCnt == RFC_CYC)
        else $error("refresh cycle length wrong");
    AST_RFC_MAX: assert property (busyCnt <= RFC_CYC)
        else $error("refresh cycle overran");
    AST_ONE_SHOT: assert property (isRef |=> !isRef)
        else $error("refresh strobes held");
    AST_GAP_MAX: assert property (gapCnt <= 9 * INTERVAL_CYC)
        else $error("refresh gap too long");
endmodule

// File: bench/dram_refresh_and_tcr_logic_bench.sv
// bench: controller and device on one link, a second device driven here
`timescale 1ns/1ps
module dram_refresh_and_tcr_logic_bench;
    logic        clock = 1'b0;
    logic        rst_b = 1'b0;
    logic        run = 1'b1;
    logic        busyReq = 1'b0;
    logic        idleHint = 1'b0;
    logic        hotA = 1'b0;
    logic [12:0] modeA = 13'h0000;
    logic [12:0] modeB = 13'h0000;
    logic [12:0] modeThree = 13'h0000;
    logic [7:0]  tempB = 8'h1E;
    logic [4:0]  cmdB = 5'h1F;
    logic [17:0] adrB = 18'h00000;
    logic        refIssued, refDone, doneB, skipB, busyB;
    logic [6:0]  balance;
    logic [15:0] rowB;
    int          num_errors = 0;
    int          check_count = 0;
    int          nIss = 0, nDone = 0, nDoneB = 0, expRow = 0;
    logic [12:0] modes [6] = '{13'h0000, 13'h0008, 13'h0008, 13'h000C, 13'h000C, 13'h000C};
    logic [7:0]  temps [6] = '{8'h1E, 8'h1E, 8'h3C, 8'h3C, 8'h1E, 8'h5A};
    int          exps [6] = '{4, 2, 4, 2, 1, 4};
    drf_cmd_if u_drf_cmd_if();
    drf_cmd_if u_drf_cmd_if_b();
    assign {u_drf_cmd_if_b.csN, u_drf_cmd_if_b.actN, u_drf_cmd_if_b.rasN,
            u_drf_cmd_if_b.casN, u_drf_cmd_if_b.weN} = cmdB;
    assign u_drf_cmd_if_b.addr = adrB;
    assign u_drf_cmd_if_b.bg0 = 1'b0;
    always #5 clock = ~clock;
    drf_controller #(.INTERVAL_CYC(64)) u_drf_controller (.clock(clock), .rst_b(rst_b),
        .clkEn(run), .cmd(u_drf_cmd_if.ctrl), .rateSel(2'h0), .hotCase(hotA),
        .busyReq(busyReq), .idleHint(idleHint), .refIssued(refIssued), .balance(balance));
    drf_device u_drf_device (.clock(clock), .rst_b(rst_b), .clkEn(run),
        .cmd(u_drf_cmd_if.dev), .modeRegFour(modeA), .modeRegThree(modeThree),
        .caseTemp(tempB), .refBusy(), .refDone(refDone), .refSkipped(), .refreshRow(),
        .rate2x(), .rate4x());
    drf_device u_drf_device_b (.clock(clock), .rst_b(rst_b), .clkEn(run),
        .cmd(u_drf_cmd_if_b.dev), .modeRegFour(modeB), .modeRegThree(modeThree),
        .caseTemp(tempB), .refBusy(busyB), .refDone(doneB), .refSkipped(skipB),
        .refreshRow(rowB), .rate2x(), .rate4x());
    drf_link_checker #(.RFC_CYC(35), .INTERVAL_CYC(64)) u_drf_link_checker (
        .clock(clock), .rst_b(rst_b), .csN(u_drf_cmd_if.csN), .actN(u_drf_cmd_if.actN),
        .rasN(u_drf_cmd_if.rasN), .casN(u_drf_cmd_if.casN), .weN(u_drf_cmd_if.weN),
        .banksIdle(u_drf_cmd_if.banksIdle));
    always @(posedge clock)
    begin
        nIss += (refIssued === 1'b1);
        nDone += (refDone === 1'b1);
        nDoneB += (doneB === 1'b1);
    end
    task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
        check_count++;
        if (seen !== exp)
        begin
            num_errors++;
            $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic end_of_test();
        $display("errors %0d checks %0d", num_errors, check_count);
        if (num_errors == 0 && check_count > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    // useBusy: wait for the second device to go idle, else for the balance value
    task automatic waitFor(input logic [6:0] bal, input int lim, input logic useBusy);
        int i;
        for (i = 0; i < lim && (useBusy ? busyB !== 1'b0 : balance !== bal); i++)
            @(negedge clock);
        if (i == lim)
        begin
            num_errors++;
            end_of_test();
        end
        // one more edge so the done pulse of this edge is counted
        @(negedge clock);
    endtask
    // one command cycle; act low makes it an activate, not a refresh
    task automatic sendRef(input logic act, input logic [17:0] adr);
        @(negedge clock);
        cmdB = {1'b0, act, 3'h1};
        adrB = adr;
        @(negedge clock);
        cmdB = 5'h1F;
        adrB = ~adr;
    endtask
    initial
    begin
        repeat (8) @(negedge clock);
        rst_b = 1'b1;
        busyReq = 1'b1;
        waitFor(7'h08, 1200, 1'b0);
        busyReq = 1'b0;
        idleHint = 1'b1;
        waitFor(7'h78, 2000, 1'b0);
        repeat (300) @(negedge clock);
        waitFor(7'h78, 64, 1'b0);
        check("balance", {9'h000, balance}, 16'h0078);
        idleHint = 1'b0;
        repeat (40) @(negedge clock);
        check("done count", 16'(nDone), 16'(nIss));
        for (int k = 0; k < 6; k++)
        begin
            modeB = modes[k];
            tempB = temps[k];
            expRow = expRow + exps[k];
            repeat (4)
            begin
                sendRef(1'b1, 18'(k * 4683));
                waitFor(7'h7F, 60, 1'b1);
            end
            check("kept refreshes", 16'(nDoneB), 16'(expRow));
        end
        modeB = 13'h0000;
        sendRef(1'b0, 18'h3FFFF);
        repeat (40) @(negedge clock);
        check("activate ignored", 16'(nDoneB), 16'(expRow));
        sendRef(1'b1, 18'h2AAAA);
        sendRef(1'b1, 18'h15555);
        waitFor(7'h7F, 60, 1'b1);
        expRow++;
        check("refused while busy", 16'(nDoneB), 16'(expRow));
        check("row counter", rowB, 16'(expRow));
        check("idle after", {15'h0000, u_drf_cmd_if_b.banksIdle}, 16'h0001);
        end_of_test();
    end
endmodule
